/* verilog/kgp_gpio_ctrl.sv */
`timescale 1ns/1ps
module kgp_gpio_ctrl
#(
   parameter int MS_CYC = kgp_pkg::CLK_KHZ
)
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       i2c_timeout,
   input  wire logic       keyscan_sleep,
   input  wire logic [7:0] row_dir,
   input  wire logic [7:0] col_dir,
   input  wire logic [7:0] row_pp,
   input  wire logic [3:0] col_pp,
   input  wire logic       fade_target,
   input  wire logic [7:0] row_in,
   input  wire logic [7:0] col_in,
   output logic      [7:0] row_out,
   output logic      [7:0] row_oe_n,
   output logic      [7:0] col_out,
   output logic      [7:0] col_oe_n,
   output logic      [7:0] row_gpi,
   output logic      [7:0] col_gpi,
   output logic            irq_n,
   output logic            drivers_en,
   output logic            chip_shutdown,
   output logic            port_regs_rst,
   output logic      [3:0] fade_level
);
   localparam int STEP_CYC = MS_CYC * kgp_pkg::FADE_STEP_MS;
   logic [7:0]  row_val_r;
   logic [7:0]  col_val_r;
   logic [7:0]  xlat_en_r;
   logic [5:0]  gcfg_r;
   logic [4:0]  db_cfg_r;
   logic        to_flag_r;
   logic        to_flag_nxt;
   logic [7:0]  rdata_r;
   logic        irq_n_r;
   logic        pen_r;
   logic        shdn_r;
   logic        prst_r;
   logic [7:0]  row_out_r;
   logic [7:0]  row_oe_n_r;
   logic [7:0]  col_out_r;
   logic [7:0]  col_oe_n_r;
   logic [15:0] s1_r;
   logic [15:0] s2_r;
   logic [15:0] s3_r;
   logic [15:0] filt_r;
   logic [15:0] gpi_r;
   logic [5:0]  db_cnt_r [16];
   logic [17:0] ms_cnt_r;
   logic        ms_tick;
   logic [5:0]  db_lim;
   logic [15:0] in_dir;
   logic [27:0] fade_cnt_r;
   logic [27:0] fade_lim;
   logic [3:0]  fade_r;
   logic        wr_ok;
   logic        prst_wr;
   logic        to_rd;
   logic [7:0]  row_f;
   logic [7:0]  col_f;
   function automatic logic in_port_range(input logic [7:0] a);
      in_port_range = (a >= kgp_pkg::OFS_RANGE_LO) &&
                      (a <= kgp_pkg::OFS_RANGE_HI);
   endfunction
   assign pen_r   = gcfg_r[kgp_pkg::GCFG_PEN];
   // config register stays writable so the port can be re-enabled
   assign wr_ok   = reg_wr && (pen_r || !in_port_range(reg_addr) ||
                    reg_addr == kgp_pkg::OFS_GCFG);
   assign prst_wr = reg_wr && reg_addr == kgp_pkg::OFS_GCFG &&
                    reg_wdata[kgp_pkg::GCFG_PRST];
   assign to_rd   = reg_rd && reg_addr == kgp_pkg::OFS_TO_FLAG;
   assign row_f   = filt_r[7:0];
   assign col_f   = filt_r[15:8];
   // port registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         row_val_r <= kgp_pkg::RST_ROW_VAL;
         col_val_r <= kgp_pkg::RST_COL_VAL;
         xlat_en_r <= kgp_pkg::RST_XLAT_EN;
         gcfg_r    <= kgp_pkg::RST_GCFG;
         db_cfg_r  <= kgp_pkg::RST_DB_CFG;
      end
      else if (prst_wr)
      begin
         row_val_r <= kgp_pkg::RST_ROW_VAL;
         col_val_r <= kgp_pkg::RST_COL_VAL;
         xlat_en_r <= kgp_pkg::RST_XLAT_EN;
         gcfg_r    <= kgp_pkg::RST_GCFG;
         db_cfg_r  <= kgp_pkg::RST_DB_CFG;
      end
      else if (wr_ok)
      begin
         case (reg_addr)
            kgp_pkg::OFS_ROW_VAL: row_val_r <= reg_wdata;
            kgp_pkg::OFS_COL_VAL: col_val_r <= reg_wdata;
            kgp_pkg::OFS_XLAT_EN: xlat_en_r <= reg_wdata;
            // reset bit is never stored, so it reads as zero
            kgp_pkg::OFS_GCFG:
               gcfg_r <= {reg_wdata[5:4], 1'b0, reg_wdata[2:0]};
            kgp_pkg::OFS_DB_CFG:  db_cfg_r  <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end
   // a timeout in the reading cycle survives the read
   assign to_flag_nxt = i2c_timeout || (to_flag_r && !to_rd);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         to_flag_r <= 1'b0;
         irq_n_r   <= 1'b1;
      end
      else
      begin
         to_flag_r <= to_flag_nxt;
         irq_n_r   <= !(to_flag_nxt &&
                        gcfg_r[kgp_pkg::GCFG_TO_IE]);
      end
   end
   // read data, one cycle after the strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_r <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            kgp_pkg::OFS_ROW_VAL: rdata_r <= row_val_r;
            kgp_pkg::OFS_COL_VAL: rdata_r <= col_val_r;
            kgp_pkg::OFS_XLAT_EN: rdata_r <= xlat_en_r;
            kgp_pkg::OFS_GCFG:    rdata_r <= {2'h0, gcfg_r};
            kgp_pkg::OFS_DB_CFG:  rdata_r <= {3'h0, db_cfg_r};
            kgp_pkg::OFS_TO_FLAG: rdata_r <= {7'h00, to_flag_r};
            default:              rdata_r <= 8'h00;
         endcase
      end
   end
   // power control
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         drivers_en <= 1'b0;
         shdn_r     <= 1'b0;
         prst_r     <= 1'b0;
      end
      else
      begin
         drivers_en <= pen_r;
         shdn_r     <= !pen_r && keyscan_sleep;
         prst_r     <= prst_wr;
      end
   end
   // pin synchronisers: a bit moves once stages two and three agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_r   <= 16'hffff;
         s2_r   <= 16'hffff;
         s3_r   <= 16'hffff;
         filt_r <= 16'hffff;
      end
      else
      begin
         s1_r   <= {col_in, row_in};
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
      end
   end
   // pin drivers; outputs keep working with port enable low
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         row_out_r  <= 8'hff;
         row_oe_n_r <= 8'hff;
         col_out_r  <= 8'hff;
         col_oe_n_r <= 8'hff;
      end
      else
      begin
         for (int n = 0; n < 8; n++)
         begin
            // column direction picks which side is driven
            if (xlat_en_r[n] && col_dir[n])
            begin
               col_out_r[n]  <= row_f[n];
               col_oe_n_r[n] <= (n >= 4 || !col_pp[n[1:0]]) ?
                                row_f[n] : 1'b0;
               row_out_r[n]  <= row_val_r[n];
               row_oe_n_r[n] <= 1'b1;
            end
            else if (xlat_en_r[n])
            begin
               row_out_r[n]  <= col_f[n];
               row_oe_n_r[n] <= row_pp[n] ? 1'b0 : col_f[n];
               col_out_r[n]  <= col_val_r[n];
               col_oe_n_r[n] <= 1'b1;
            end
            else
            begin
               row_out_r[n]  <= row_val_r[n];
               row_oe_n_r[n] <= !row_dir[n] ||
                                (!row_pp[n] && row_val_r[n]);
               col_out_r[n]  <= col_val_r[n];
               // upper columns are open drain only, high needs pullup
               col_oe_n_r[n] <= !col_dir[n] || (col_val_r[n] &&
                                (n >= 4 || !col_pp[n[1:0]]));
            end
         end
      end
   end
   // one millisecond tick for debounce
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ms_cnt_r <= 18'h00000;
      else
         ms_cnt_r <= ms_tick ? 18'h00000 : ms_cnt_r + 18'h00001;
   end
   assign ms_tick = ms_cnt_r == 18'(MS_CYC - 1);
   // tick phase is free running, so the wait may be up to 1 ms short
   assign db_lim  = 6'(kgp_pkg::DB_BASE_MS) + {1'b0, db_cfg_r};
   assign in_dir  = ~{col_dir, row_dir};
   // general inputs; frozen while the port is disabled
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gpi_r <= 16'hffff;
         for (int i = 0; i < 16; i++)
            db_cnt_r[i] <= 6'h00;
      end
      else if (pen_r)
      begin
         for (int i = 0; i < 16; i++)
         begin
            if (!in_dir[i] || filt_r[i] == gpi_r[i])
               db_cnt_r[i] <= 6'h00;
            else if (ms_tick)
            begin
               if (db_cnt_r[i] + 6'h01 >= db_lim)
               begin
                  gpi_r[i]    <= filt_r[i];
                  db_cnt_r[i] <= 6'h00;
               end
               else
                  db_cnt_r[i] <= db_cnt_r[i] + 6'h01;
            end
         end
      end
   end
   // step length doubles with each fade code above one
   assign fade_lim = 28'(STEP_CYC) << (gcfg_r[kgp_pkg::GCFG_FADE_HI:0]
                     - 3'h1);
   // fade ramp toward full or zero intensity
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fade_r     <= 4'h0;
         fade_cnt_r <= 28'h0000000;
      end
      else if (!pen_r)
         fade_cnt_r <= 28'h0000000;
      else if (gcfg_r[kgp_pkg::GCFG_FADE_HI:0] == 3'h0 ||
               gcfg_r[kgp_pkg::GCFG_FADE_HI:0] > kgp_pkg::FADE_MAX_CODE)
      begin
         fade_r     <= fade_target ? 4'hf : 4'h0;
         fade_cnt_r <= 28'h0000000;
      end
      else if (fade_cnt_r + 28'h1 >= fade_lim)
      begin
         fade_cnt_r <= 28'h0000000;
         if (fade_target && fade_r != 4'hf)
            fade_r <= fade_r + 4'h1;
         else if (!fade_target && fade_r != 4'h0)
            fade_r <= fade_r - 4'h1;
      end
      else
         fade_cnt_r <= fade_cnt_r + 28'h1;
   end
   assign reg_rdata     = rdata_r;
   assign irq_n         = irq_n_r;
   assign chip_shutdown = shdn_r;
   assign port_regs_rst = prst_r;
   assign row_out       = row_out_r;
   assign row_oe_n      = row_oe_n_r;
   assign col_out       = col_out_r;
   assign col_oe_n      = col_oe_n_r;
   assign row_gpi       = gpi_r[7:0];
   assign col_gpi       = gpi_r[15:8];
   assign fade_level    = fade_r;
   default clocking kgp_cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_row_line_0_plain;
      row_dir[0] && !xlat_en_r[0];
   endsequence
   property p_row_drive;
      s_row_line_0_plain |=> row_out_r[0] == $past(row_val_r[0]);
   endproperty
   a_row_drive: assert property (p_row_drive)
      else $error("row 0 does not follow its value bit");
   property p_col_od;
      (col_dir[7] && !xlat_en_r[7])
      |=> col_oe_n_r[7] == $past(col_val_r[7]);
   endproperty
   a_col_od: assert property (p_col_od)
      else $error("column 7 not open drain on its value");
   property p_xlat;
      (xlat_en_r[0] && col_dir[0])
      |=> col_out_r[0] == $past(row_f[0]);
   endproperty
   a_xlat: assert property (p_xlat)
      else $error("column 0 does not copy row 0");
   property p_xlat_rst;
      !$past(rstn) |-> xlat_en_r == 8'h00;
   endproperty
   a_xlat_rst: assert property (p_xlat_rst)
      else $error("translator enables not zero after reset");
   sequence s_to_hit;
      i2c_timeout && gcfg_r[kgp_pkg::GCFG_TO_IE];
   endsequence
   property p_irq_set;
      s_to_hit |=> !irq_n_r && to_flag_r;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("timeout did not raise the interrupt");
   sequence s_flag_read;
      to_rd && !i2c_timeout;
   endsequence
   // a timeout just after the read may raise it again
   property p_irq_clr;
      s_flag_read |=> (irq_n_r && !to_flag_r)
                      ##1 (irq_n_r || $past(i2c_timeout));
   endproperty
   a_irq_clr: assert property (p_irq_clr)
      else $error("flag read did not drop the interrupt");
   property p_wr_block;
      (!pen_r && reg_wr && reg_addr == kgp_pkg::OFS_ROW_VAL)
      |=> $stable(row_val_r);
   endproperty
   a_wr_block: assert property (p_wr_block)
      else $error("write changed a port register while disabled");
   property p_prst;
      prst_wr |=> xlat_en_r == kgp_pkg::RST_XLAT_EN &&
                  !gcfg_r[kgp_pkg::GCFG_PRST] && prst_r;
   endproperty
   a_prst: assert property (p_prst)
      else $error("port reset did not restore registers");
   property p_shdn;
      ##1 shdn_r == ($past(!pen_r) && $past(keyscan_sleep));
   endproperty
   a_shdn: assert property (p_shdn)
      else $error("shutdown does not follow enable and sleep");
endmodule // kgp_gpio_ctrl

/* verilog/kgp_pkg.sv */
package kgp_pkg;
   localparam logic [7:0] OFS_RANGE_LO = 8'h31;
   localparam logic [7:0] OFS_RANGE_HI = 8'h5b;
   localparam logic [7:0] OFS_ROW_VAL  = 8'h3a;
   localparam logic [7:0] OFS_COL_VAL  = 8'h3b;
   localparam logic [7:0] OFS_XLAT_EN  = 8'h3c;
   localparam logic [7:0] OFS_GCFG     = 8'h40;
   localparam logic [7:0] OFS_DB_CFG   = 8'h42;
   localparam logic [7:0] OFS_TO_FLAG  = 8'h48;
   localparam int         GCFG_TO_IE   = 5;
   localparam int         GCFG_PEN     = 4;
   localparam int         GCFG_PRST    = 3;
   localparam int         GCFG_FADE_HI = 2;
   localparam logic [7:0] RST_ROW_VAL  = 8'hff;
   localparam logic [7:0] RST_COL_VAL  = 8'hff;
   localparam logic [7:0] RST_XLAT_EN  = 8'h00;
   localparam logic [5:0] RST_GCFG     = 6'h00;
   localparam logic [4:0] RST_DB_CFG   = 5'h00;
   localparam int         CLK_KHZ      = 40000;
   localparam int         DB_BASE_MS   = 9;
   localparam int         FADE_MIN_MS  = 256;
   localparam int         FADE_STEPS   = 16;
   localparam int         FADE_STEP_MS = FADE_MIN_MS / FADE_STEPS;
   localparam logic [2:0] FADE_MAX_CODE = 3'h5;
endpackage

/* verif/kgp_host_model.sv */
`timescale 1ns/1ps
module kgp_host_model
(
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic            i2c_timeout
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      i2c_timeout = 1'b0;
   end

   // released data shows the inverse so stale bytes never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic bus_timeout();
      @(posedge clk);
      i2c_timeout <= 1'b1;
      @(posedge clk);
      i2c_timeout <= 1'b0;
   endtask
endmodule // kgp_host_model

/* verif/keypad_gpio_output_and_global_control_tb.sv */
`timescale 1ns/1ps
module keypad_gpio_output_and_global_control_tb;
   localparam int MS = 8;
   logic       clk, rstn, reg_wr, reg_rd, i2c_timeout, keyscan_sleep;
   logic       fade_target, irq_n, drivers_en, chip_shutdown;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, row_dir, col_dir, row_pp;
   logic [3:0] col_pp, fade_level;
   logic [7:0] row_in, col_in, row_out, row_oe_n, col_out, col_oe_n;
   logic [7:0] row_gpi, col_gpi, row_ext, col_ext;
   logic       port_regs_rst;
   int         error_cnt, n_checks;

   // pins: driven level where enabled, else the outside world (pullup)
   assign row_in = (row_oe_n & row_ext) | (~row_oe_n & row_out);
   assign col_in = (col_oe_n & col_ext) | (~col_oe_n & col_out);

   kgp_gpio_ctrl #(.MS_CYC(MS)) u_dut
   (
      .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .i2c_timeout(i2c_timeout), .keyscan_sleep(keyscan_sleep),
      .row_dir(row_dir), .col_dir(col_dir), .row_pp(row_pp),
      .col_pp(col_pp), .fade_target(fade_target), .row_in(row_in),
      .col_in(col_in), .row_out(row_out), .row_oe_n(row_oe_n),
      .col_out(col_out), .col_oe_n(col_oe_n), .row_gpi(row_gpi),
      .col_gpi(col_gpi), .irq_n(irq_n), .drivers_en(drivers_en),
      .chip_shutdown(chip_shutdown), .port_regs_rst(port_regs_rst),
      .fade_level(fade_level)
   );

   kgp_host_model u_host
   (
      .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .i2c_timeout(i2c_timeout)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic t_reset();
      rchk(8'h3c, 8'h00);
      rchk(8'h40, 8'h00);
      rchk(8'h42, 8'h00);
      rchk(8'h48, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
   endtask

   // port disabled: outputs live, registers frozen, sleep kills the part
   task automatic t_disabled();
      @(posedge clk);
      row_dir <= 8'hff;
      keyscan_sleep <= 1'b1;
      cyc(4);
      chk(row_oe_n, 8'h00);
      chk(row_in, 8'hff);
      chk({6'h00, drivers_en, chip_shutdown}, 8'h01);
      u_host.wr(8'h3a, 8'h00);
      u_host.wr(8'h3c, 8'h0f);
      rchk(8'h3a, 8'hff);
      rchk(8'h3c, 8'h00);
   endtask

   task automatic t_outputs();
      u_host.wr(8'h40, 8'h10);
      cyc(2);
      chk({6'h00, drivers_en, chip_shutdown}, 8'h02);
      u_host.wr(8'h3a, 8'h5a);
      @(posedge clk);
      col_dir <= 8'hff;
      u_host.wr(8'h3b, 8'ha5);
      cyc(3);
      chk(row_in, 8'h5a);
      chk(col_oe_n, 8'ha0);
      chk(col_in, 8'ha5);
   endtask

   task automatic t_timeout();
      u_host.wr(8'h40, 8'h30);
      u_host.bus_timeout();
      cyc(2);
      chk({7'h00, irq_n}, 8'h00);
      rchk(8'h48, 8'h01);
      chk({7'h00, irq_n}, 8'h01);
      rchk(8'h48, 8'h00);
      u_host.wr(8'h40, 8'h10);
      u_host.bus_timeout();
      cyc(3);
      chk({7'h00, irq_n}, 8'h01);
      rchk(8'h48, 8'h01);
   endtask

   // pair 0: row pin in, column pin out
   task automatic t_xlat();
      @(posedge clk);
      row_dir <= 8'h00;
      col_dir <= 8'h01;
      row_ext <= 8'hfe;
      u_host.wr(8'h3c, 8'h01);
      cyc(8);
      chk({7'h00, col_in[0]}, 8'h00);
      chk({7'h00, col_oe_n[0]}, 8'h00);
      @(posedge clk);
      row_ext <= 8'hff;
      cyc(8);
      chk({7'h00, col_out[0]}, 8'h01);
      chk(row_oe_n, 8'hff);
   endtask

   task automatic t_debounce();
      u_host.wr(8'h42, 8'hff);
      rchk(8'h42, 8'h1f);
      u_host.wr(8'h42, 8'h02);
      cyc(45 * MS);
      chk(row_gpi, 8'hff);
      chk(col_gpi, 8'hff);
      @(posedge clk);
      row_ext <= 8'h3c;
      col_ext <= 8'h0f;
      // a 9 ms wait would have accepted by now, 11 ms not yet
      cyc(9 * MS + 4);
      chk(row_gpi, 8'hff);
      cyc(7 * MS);
      chk(row_gpi, 8'h3c);
      chk(col_gpi, 8'h0f);
   endtask

   task automatic t_fade();
      // code first: with fading off the level jumps to the target
      u_host.wr(8'h40, 8'h11);
      @(posedge clk);
      fade_target <= 1'b1;
      // 16 ms steps at code 001: two steps done after 40 ms
      cyc(40 * MS);
      chk({4'h0, fade_level}, 8'h02);
      cyc(250 * MS);
      chk({4'h0, fade_level}, 8'h0f);
      @(posedge clk);
      fade_target <= 1'b0;
      u_host.wr(8'h40, 8'h10);
      cyc(3);
      chk({4'h0, fade_level}, 8'h00);
   endtask

   task automatic t_port_reset();
      u_host.wr(8'h3c, 8'hff);
      u_host.wr(8'h3a, 8'h00);
      u_host.wr(8'h40, 8'h18);
      #1;
      chk({7'h00, port_regs_rst}, 8'h01);
      cyc(1);
      chk({7'h00, port_regs_rst}, 8'h00);
      rchk(8'h40, 8'h00);
      rchk(8'h3c, 8'h00);
      rchk(8'h3a, 8'hff);
      rchk(8'h42, 8'h00);
   endtask

   initial
   begin
      error_cnt = 0;
      n_checks = 0;
      rstn = 1'b0;
      keyscan_sleep = 1'b0;
      fade_target = 1'b0;
      row_dir = 8'h00;
      col_dir = 8'h00;
      row_pp = 8'hff;
      col_pp = 4'hf;
      row_ext = 8'hff;
      col_ext = 8'hff;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_disabled();
      t_outputs();
      t_timeout();
      t_xlat();
      t_debounce();
      t_fade();
      t_port_reset();
      end_sim();
   end

   // whole run is a few thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
endmodule // keypad_gpio_output_and_global_control_tb
